// >>> hw/spio_pkg.sv
// Constants for the shared pin I/O ports
package spio_pkg;
  localparam int          NIB            = 4;
  localparam int          PB_W           = 8;
  localparam int          PC_W           = 4;
  localparam int          PA_BIT         = 7;
  localparam int          SPI_PINS       = 3;
  localparam logic [3:0]  OFS_PORTA      = 4'h0;
  localparam logic [3:0]  OFS_PORT_B_PINS      = 4'h1;
  localparam logic [3:0]  OFS_PORT_C_PINS      = 4'h2;
  localparam logic [3:0]  OFS_PULL       = 4'h9;
  localparam logic [3:0]  OFS_ODRAIN     = 4'ha;
  localparam logic [3:0]  OFS_LCD        = 4'hb;
  localparam logic [3:0]  OFS_SERIAL     = 4'hc;
  localparam logic        MAP_NORMAL     = 1'b0;
  localparam logic        MAP_OPTION     = 1'b1;
  localparam int          IDX_LSB        = 2;
  localparam int          IDX_MSB        = 6;
  localparam int          PULL_B_LOW     = 0;
  localparam int          PULL_B_HIGH    = 1;
  localparam int          PULL_A_HIGH    = 2;
  localparam int          PULL_C         = 3;
  localparam int          OD_B_LOW       = 0;
  localparam int          OD_B_HIGH      = 1;
  localparam int          OD_A_HIGH      = 2;
  localparam int          OD_C           = 3;
  localparam int          LCD_PORT_B_LOW_PORT_ENABLE       = 0;
  localparam int          LCD_PORT_B_HIGH_PORT_ENABLE       = 1;
  localparam int          SER_SPE        = 0;
  localparam int          SER_SERIAL_MASTER_SELECT       = 1;
  localparam int          PC_OD_FIRST    = 2;
  localparam logic [7:0]  CTRL_RST       = 8'h00;
  localparam logic [31:0] DAT_ZERO       = 32'h0000_0000;
endpackage : spio_pkg

// >>> hw/spio_top.sv
// Port A bit 7, port B and port C pin logic with Wishbone register access
// Behaviour
// - PA7 input with pull when direction 0; output push-pull or open-drain when 1.
// - PA7 as input: write only updates latch; read returns pin.
// - Port B has eight pins shared with LCD frontplane, each with direction and data.
// - Port B data at normal offset 1; direction at option offset 1.
// - Reset clears all port B direction bits.
// - Reset selects LCD on all port B pins; data latch keeps contents.
// - Port B output pin follows its latch bit; reads return latch.
// - Port B input pin: read returns pin level.
// - Port B direction 0 means input, 1 means output.
// - Port B pull-ups per nibble from pull select bits; cleared at reset.
// - Port B per-nibble open-drain: low for 0, release for 1; cleared at reset.
// - Low port enable 0: pins 0-3 are LCD, read 0, write latch only.
// - High port enable 0: pins 4-7 are LCD, read 0, write latch only.
// - Port B input or LCD pin: data write touches latch only.
// - Port C four pins; data at 2, pull at option 9, open-drain option A.
// - Serial enable makes C0-C2 serial clock, data out, data in; clock per master.
// - Port C read always returns actual pin levels.
// - Port C pin 3 level is readable at any time.
// - Port C pins 2 and 3 are always open-drain when outputs.
module spio_top
  import spio_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [31:0]       adr_i,
  input  wire logic [3:0]        sel_i,
  input  wire logic [31:0]       dat_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  input  wire logic              pa7_i,
  output logic                   pa7_o,
  output logic                   pa7_oe_o,
  output logic                   pa7_pull_o,
  input  wire logic [PB_W-1:0]   pb_i,
  output logic      [PB_W-1:0]   pb_o,
  output logic      [PB_W-1:0]   pb_oe_o,
  output logic      [PB_W-1:0]   pb_pull_o,
  input  wire logic [PB_W-1:0]   lcd_frontplane_i,
  input  wire logic [PC_W-1:0]   pc_i,
  output logic      [PC_W-1:0]   pc_o,
  output logic      [PC_W-1:0]   pc_oe_o,
  output logic      [PC_W-1:0]   pc_pull_o,
  input  wire logic              spi_sck_out_i,
  input  wire logic              spi_sdo_i,
  output logic                   spi_sck_in_o,
  output logic                   spi_sdi_o,
  output logic                   serial_enable_bit_o,
  output logic                   serial_master_select_o,
  output logic                   irq_pin_o
);

  logic [7:0]      pa_latch_q;
  logic [7:0]      pb_latch_q;
  logic [7:0]      pc_latch_q;
  logic            porta_pin_seven_direction_q;
  logic [7:0]      port_b_direction_q;
  logic [7:0]      port_c_direction_q;
  logic [7:0]      pull_resistor_control_q;
  logic [7:0]      open_drain_control_q;
  logic [7:0]      lcd_control_q;
  logic [7:0]      serial_control_q;
  logic            ack_q;
  logic [31:0]     dat_q;
  logic [12:0]     meta_q;
  logic [12:0]     sync_q;
  logic            pa7_out_q;
  logic            pa7_oe_q;
  logic            pa7_pull_q;
  logic [PB_W-1:0] pb_out_q;
  logic [PB_W-1:0] pb_oe_q;
  logic [PB_W-1:0] pb_pull_q;
  logic [PC_W-1:0] pc_out_q;
  logic [PC_W-1:0] pc_oe_q;
  logic [PC_W-1:0] pc_pull_q;

  // Decode
  wire             req      = cyc_i & stb_i;
  wire             adr_ok   = (adr_i[31:IDX_MSB+1] == '0) & (adr_i[IDX_LSB-1:0] == '0);
  wire             map_sel  = adr_i[IDX_MSB];
  wire [3:0]       ofs      = adr_i[IDX_MSB-1:IDX_LSB];
  wire             wr       = req & we_i & ack_q & sel_i[0] & adr_ok;
  wire             hit_n    = adr_ok & (map_sel == MAP_NORMAL);
  wire             hit_o    = adr_ok & (map_sel == MAP_OPTION);
  wire             wr_pa    = wr & hit_n & (ofs == OFS_PORTA);
  wire             wr_pb    = wr & hit_n & (ofs == OFS_PORT_B_PINS);
  wire             wr_pc    = wr & hit_n & (ofs == OFS_PORT_C_PINS);
  wire             wr_pa_d  = wr & hit_o & (ofs == OFS_PORTA);
  wire             wr_pb_d  = wr & hit_o & (ofs == OFS_PORT_B_PINS);
  wire             wr_pc_d  = wr & hit_o & (ofs == OFS_PORT_C_PINS);
  wire             wr_pull  = wr & hit_o & (ofs == OFS_PULL);
  wire             wr_od    = wr & hit_o & (ofs == OFS_ODRAIN);
  wire             wr_lcd   = wr & hit_o & (ofs == OFS_LCD);
  wire             wr_ser   = wr & hit_o & (ofs == OFS_SERIAL);

  // Synchronised pins
  wire             pa7_s    = sync_q[12];
  wire [PB_W-1:0]  pb_s     = sync_q[11:4];
  wire [PC_W-1:0]  pc_s     = sync_q[3:0];

  wire             serial_enable_bit      = serial_control_q[SER_SPE];
  wire             serial_master_select     = serial_control_q[SER_SERIAL_MASTER_SELECT];
  wire             cwom     = open_drain_control_q[OD_C];
  wire             porta_high_open_drain    = open_drain_control_q[OD_A_HIGH];

  // Port A bit 7
  wire             pa7_l    = pa_latch_q[PA_BIT];
  wire             pa7_dir  = porta_pin_seven_direction_q;
  wire             pa7_oe_d = pa7_dir & (~porta_high_open_drain | ~pa7_l);
  wire             pa7_o_d  = pa7_l & ~porta_high_open_drain;
  wire             pa7_pu_d = pull_resistor_control_q[PULL_A_HIGH] & ~pa7_oe_d;
  wire             pa7_rd   = pa7_dir ? pa7_l : pa7_s;

  // Port B, one slice per pin
  logic [PB_W-1:0] pb_oe_d;
  logic [PB_W-1:0] pb_o_d;
  logic [PB_W-1:0] pb_pu_d;
  logic [PB_W-1:0] pb_rd;
  genvar gi;
  generate
    for (gi = 0; gi < PB_W; gi++) begin : g_pb
      localparam int N = gi / NIB;
      wire pbe = lcd_control_q[LCD_PORT_B_LOW_PORT_ENABLE + N];
      wire wom = open_drain_control_q[OD_B_LOW + N];
      wire pu  = pull_resistor_control_q[PULL_B_LOW + N];
      wire dir = port_b_direction_q[gi];
      wire lat = pb_latch_q[gi];
      // LCD owns the pin while the port is disabled, whatever the direction
      assign pb_oe_d[gi] = ~pbe | (dir & (~wom | ~lat));
      assign pb_o_d[gi]  = pbe ? (lat & ~wom) : lcd_frontplane_i[gi];
      assign pb_pu_d[gi] = pu;
      assign pb_rd[gi]   = pbe & (dir ? lat : pb_s[gi]);
    end
  endgenerate

  // Port C
  logic [PC_W-1:0] pc_oe_d;
  logic [PC_W-1:0] pc_o_d;
  logic [PC_W-1:0] spi_oe;
  logic [PC_W-1:0] spi_out;
  assign spi_oe  = {1'b0, 1'b0, (~cwom | ~spi_sdo_i), serial_master_select & (~cwom | ~spi_sck_out_i)};
  assign spi_out = {1'b0, 1'b0, spi_sdo_i & ~cwom, spi_sck_out_i & ~cwom};
  generate
    for (gi = 0; gi < PC_W; gi++) begin : g_pc
      // Pins 2 and 3 have no high drive at all
      wire od  = (gi >= PC_OD_FIRST) ? 1'b1 : cwom;
      wire lat = pc_latch_q[gi];
      wire sp  = serial_enable_bit & (gi < SPI_PINS);
      assign pc_oe_d[gi] = sp ? spi_oe[gi] : (port_c_direction_q[gi] & (~od | ~lat));
      assign pc_o_d[gi]  = sp ? spi_out[gi] : (lat & ~od);
    end
  endgenerate
  wire [PC_W-1:0]  pc_pu_d  = {PC_W{pull_resistor_control_q[PULL_C]}} & ~pc_oe_d;
  wire [PC_W-1:0]  pc_rd    = pc_s;

  // Read mux
  wire [7:0] rd_n = (ofs == OFS_PORTA) ? {pa7_rd, 7'h00} :
                    (ofs == OFS_PORT_B_PINS) ? pb_rd :
                    (ofs == OFS_PORT_C_PINS) ? {4'h0, pc_rd} : 8'h00;
  wire [7:0] rd_o = (ofs == OFS_PORTA) ? {pa7_dir, 7'h00} :
                    (ofs == OFS_PORT_B_PINS) ? port_b_direction_q :
                    (ofs == OFS_PORT_C_PINS) ? port_c_direction_q :
                    (ofs == OFS_PULL)  ? pull_resistor_control_q :
                    (ofs == OFS_ODRAIN) ? open_drain_control_q :
                    (ofs == OFS_LCD)   ? lcd_control_q :
                    (ofs == OFS_SERIAL) ? serial_control_q : 8'h00;
  wire [31:0] rdata = !adr_ok ? DAT_ZERO : {24'h000000, (map_sel == MAP_OPTION) ? rd_o : rd_n};

  // Data latches keep their value across reset
  always_ff @(posedge clk_i) begin
    if (wr_pa) pa_latch_q <= dat_i[7:0];
    if (wr_pb) pb_latch_q <= dat_i[7:0];
    if (wr_pc) pc_latch_q <= dat_i[7:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      porta_pin_seven_direction_q <= 1'b0;
      port_b_direction_q          <= CTRL_RST;
      port_c_direction_q          <= CTRL_RST;
      pull_resistor_control_q     <= CTRL_RST;
      open_drain_control_q        <= CTRL_RST;
      lcd_control_q               <= CTRL_RST;
      serial_control_q            <= CTRL_RST;
    end else begin
      if (wr_pa_d) porta_pin_seven_direction_q <= dat_i[PA_BIT];
      if (wr_pb_d) port_b_direction_q <= dat_i[7:0];
      if (wr_pc_d) port_c_direction_q <= {4'h0, dat_i[3:0]};
      if (wr_pull) pull_resistor_control_q <= {4'h0, dat_i[3:0]};
      if (wr_od)   open_drain_control_q <= {4'h0, dat_i[3:0]};
      if (wr_lcd)  lcd_control_q <= {6'h00, dat_i[1:0]};
      if (wr_ser)  serial_control_q <= {6'h00, dat_i[1:0]};
    end
  end

  // Bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= DAT_ZERO;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) dat_q <= rdata;
    end
  end

  // Two-stage synchroniser on every pad input
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {pa7_i, pb_i, pc_i};
      sync_q <= meta_q;
    end
  end

  // Registered pad drive avoids glitches on the board during register updates
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa7_out_q  <= 1'b0;
      pa7_oe_q   <= 1'b0;
      pa7_pull_q <= 1'b0;
      pb_out_q   <= '0;
      pb_oe_q    <= '0;
      pb_pull_q  <= '0;
      pc_out_q   <= '0;
      pc_oe_q    <= '0;
      pc_pull_q  <= '0;
    end else begin
      pa7_out_q  <= pa7_o_d;
      pa7_oe_q   <= pa7_oe_d;
      pa7_pull_q <= pa7_pu_d;
      pb_out_q   <= pb_o_d;
      pb_oe_q    <= pb_oe_d;
      pb_pull_q  <= pb_pu_d;
      pc_out_q   <= pc_o_d;
      pc_oe_q    <= pc_oe_d;
      pc_pull_q  <= pc_pu_d;
    end
  end

  assign dat_o                  = dat_q;
  assign ack_o                  = ack_q;
  assign pa7_o                  = pa7_out_q;
  assign pa7_oe_o               = pa7_oe_q;
  assign pa7_pull_o             = pa7_pull_q;
  assign pb_o                   = pb_out_q;
  assign pb_oe_o                = pb_oe_q;
  assign pb_pull_o              = pb_pull_q;
  assign pc_o                   = pc_out_q;
  assign pc_oe_o                = pc_oe_q;
  assign pc_pull_o              = pc_pull_q;
  assign spi_sck_in_o           = pc_s[0];
  assign spi_sdi_o              = pc_s[2];
  assign irq_pin_o              = pc_s[3];
  assign serial_enable_bit_o    = serial_enable_bit;
  assign serial_master_select_o = serial_master_select;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pa7_in;
    !pa7_dir |=> !pa7_oe_o;
  endproperty
  a_pa7_in: assert property (p_pa7_in) else $error("PA7 driven while input");

  property p_pa7_rd;
    req && !ack_q && !we_i && hit_n && (ofs == OFS_PORTA) && !pa7_dir
      |=> dat_o[PA_BIT] == $past(pa7_s);
  endproperty
  a_pa7_rd: assert property (p_pa7_rd) else $error("PA7 read not pin");

  property p_rst_dir;
    $fell(rst_i) |-> port_b_direction_q == CTRL_RST && lcd_control_q == CTRL_RST;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("Port B reset state wrong");

  property p_pb_out;
    lcd_control_q[LCD_PORT_B_LOW_PORT_ENABLE] && port_b_direction_q[0] && !open_drain_control_q[OD_B_LOW]
      |=> pb_oe_o[0] && pb_o[0] == $past(pb_latch_q[0]);
  endproperty
  a_pb_out: assert property (p_pb_out) else $error("Port B output not latch");

  property p_pb_in;
    lcd_control_q[LCD_PORT_B_LOW_PORT_ENABLE] && !port_b_direction_q[0] |-> pb_rd[0] == pb_s[0];
  endproperty
  a_pb_in: assert property (p_pb_in) else $error("Port B read not pin");

  property p_pb_od;
    lcd_control_q[LCD_PORT_B_HIGH_PORT_ENABLE] && port_b_direction_q[7] && open_drain_control_q[OD_B_HIGH]
      && pb_latch_q[7] |=> !pb_oe_o[7];
  endproperty
  a_pb_od: assert property (p_pb_od) else $error("Open drain drives high");

  property p_pb_lcd;
    !lcd_control_q[LCD_PORT_B_LOW_PORT_ENABLE] |-> pb_rd[3:0] == 4'h0 ##1 pb_oe_o[3:0] == 4'hf;
  endproperty
  a_pb_lcd: assert property (p_pb_lcd) else $error("LCD nibble wrong");

  property p_pc_od;
    !serial_enable_bit && port_c_direction_q[3] && pc_latch_q[3] |=> !pc_oe_o[3];
  endproperty
  a_pc_od: assert property (p_pc_od) else $error("PC3 drives high");

  property p_pc_rd;
    req && !ack_q && !we_i && hit_n && (ofs == OFS_PORT_C_PINS)
      |=> dat_o[7:0] == {4'h0, $past(pc_s)};
  endproperty
  a_pc_rd: assert property (p_pc_rd) else $error("Port C read not pin");

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("Ack held too long");

  property p_ack_resp;
    req && !ack_q |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("Request not answered");

  property p_pb_dir_wr;
    wr_pb_d |=> port_b_direction_q == $past(dat_i[7:0]);
  endproperty
  a_pb_dir_wr: assert property (p_pb_dir_wr) else $error("Port B direction not stored");

  property p_pb_in_rel;
    lcd_control_q[LCD_PORT_B_LOW_PORT_ENABLE] && !port_b_direction_q[0] |=> !pb_oe_o[0];
  endproperty
  a_pb_in_rel: assert property (p_pb_in_rel) else $error("Port B input pin driven");

  property p_pb_pull;
    pull_resistor_control_q[PULL_B_HIGH] |=> pb_pull_o[PB_W-1:NIB] == 4'hf;
  endproperty
  a_pb_pull: assert property (p_pb_pull) else $error("Port B pull-up missing");

  property p_pb_hi_lcd;
    !lcd_control_q[LCD_PORT_B_HIGH_PORT_ENABLE] |-> pb_rd[7:4] == 4'h0 ##1 pb_oe_o[7:4] == 4'hf;
  endproperty
  a_pb_hi_lcd: assert property (p_pb_hi_lcd) else $error("LCD high nibble wrong");

  property p_rst_ctl;
    $fell(rst_i) |-> pull_resistor_control_q == CTRL_RST && open_drain_control_q == CTRL_RST;
  endproperty
  a_rst_ctl: assert property (p_rst_ctl) else $error("Pull or open-drain reset wrong");

  property p_pa7_pull;
    pull_resistor_control_q[PULL_A_HIGH] && !pa7_dir |=> pa7_pull_o;
  endproperty
  a_pa7_pull: assert property (p_pa7_pull) else $error("PA7 input pull-up missing");

  property p_pa7_cmos;
    pa7_dir && !porta_high_open_drain |=> pa7_oe_o && pa7_o == $past(pa7_l);
  endproperty
  a_pa7_cmos: assert property (p_pa7_cmos) else $error("PA7 push-pull output wrong");

  property p_spi_sck;
    serial_enable_bit && !serial_master_select |=> !pc_oe_o[0];
  endproperty
  a_spi_sck: assert property (p_spi_sck) else $error("Serial clock driven as slave");

  property p_spi_sdi;
    serial_enable_bit |=> !pc_oe_o[2];
  endproperty
  a_spi_sdi: assert property (p_spi_sdi) else $error("Serial data in driven");

  property p_pc2_od;
    !serial_enable_bit && port_c_direction_q[2] && pc_latch_q[2] |=> !pc_oe_o[2];
  endproperty
  a_pc2_od: assert property (p_pc2_od) else $error("PC2 drives high");

  property p_od_low;
    lcd_control_q[LCD_PORT_B_HIGH_PORT_ENABLE] && port_b_direction_q[5] && open_drain_control_q[OD_B_HIGH]
      && !pb_latch_q[5] |=> pb_oe_o[5] && !pb_o[5];
  endproperty
  a_od_low: assert property (p_od_low) else $error("Open drain does not pull low");

endmodule : spio_top

// >>> testbench/spio_board.sv
// Board side of the pads: external drivers, pull-ups and floating lines
module spio_board #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] o_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pull_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic      [W-1:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] last_q = '0;
  // A floating line flips every cycle so a stale value is never read as valid
  always_comb begin
    for (int k = 0; k < W; k++) begin
      pin_o[k] = oe_i[k] ? o_i[k] : ext_en_i[k] ? ext_val_i[k] : pull_i[k] ? 1'b1 : ~last_q[k];
    end
  end
  always_ff @(posedge clk_i) begin
    last_q <= pin_o;
  end
endmodule : spio_board

// >>> testbench/spio_top_tb.sv
// Self-checking bench for the shared pin ports
module spio_top_tb import spio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, sck_out = 1'b1, sdo = 1'b0;
  logic [31:0] adr = '0, wdat = '0, dat_o;
  logic [3:0]  sel = 4'h0, pc_xen = 4'h0, pc_xv = 4'h0, pc_i, pc_o, pc_oe_o, pc_pull_o;
  logic [7:0]  lcd_fp = 8'h3c, pb_xen = 8'h00, pb_xv = 8'h00, pb_i, pb_o, pb_oe_o, pb_pull_o, q;
  logic        ack_o, pa7_i, pa7_o, pa7_oe_o, pa7_pull_o, sck_in, sdi, serial_enable_bit, serial_master_select, irq;
  int          fail_count = 0, samples_checked = 0, cyc_n = 0;
  always #4 clk_i = ~clk_i;
  spio_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pa7_i(pa7_i), .pa7_o(pa7_o), .pa7_oe_o(pa7_oe_o),
    .pa7_pull_o(pa7_pull_o), .pb_i(pb_i), .pb_o(pb_o), .pb_oe_o(pb_oe_o), .pb_pull_o(pb_pull_o),
    .lcd_frontplane_i(lcd_fp), .pc_i(pc_i), .pc_o(pc_o), .pc_oe_o(pc_oe_o), .pc_pull_o(pc_pull_o),
    .spi_sck_out_i(sck_out), .spi_sdo_i(sdo), .spi_sck_in_o(sck_in), .spi_sdi_o(sdi),
    .serial_enable_bit_o(serial_enable_bit), .serial_master_select_o(serial_master_select), .irq_pin_o(irq));
  spio_board #(.W(1)) brd_a (.clk_i(clk_i), .o_i(pa7_o), .oe_i(pa7_oe_o), .pull_i(pa7_pull_o),
    .ext_en_i(1'b0), .ext_val_i(1'b0), .pin_o(pa7_i));
  spio_board #(.W(8)) brd_b (.clk_i(clk_i), .o_i(pb_o), .oe_i(pb_oe_o), .pull_i(pb_pull_o),
    .ext_en_i(pb_xen), .ext_val_i(pb_xv), .pin_o(pb_i));
  spio_board #(.W(4)) brd_c (.clk_i(clk_i), .o_i(pc_o), .oe_i(pc_oe_o), .pull_i(pc_pull_o),
    .ext_en_i(pc_xen), .ext_val_i(pc_xv), .pin_o(pc_i));
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  // Slow answers are tolerated; only the bench timeout ends a wait
  task automatic wb(input logic w, input logic [4:0] idx, input logic [7:0] d, output logic [7:0] r);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {25'h0, idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic wr(input logic [4:0] idx, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, idx, d, r);
  endtask : wr
  task automatic chk_rd(input string nm, input logic [7:0] e, input logic [4:0] idx);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    samples_checked++;
    if (r !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, r);
    end
  endtask : chk_rd
  task automatic chk_pin(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin
  task automatic settle();
    repeat (4) @(posedge clk_i);
  endtask : settle
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
  endtask : do_reset
  task automatic t_port_b();
    chk_pin("pb_oe", 8'hff, pb_oe_o);
    chk_pin("pb_out", 8'h3c, pb_o);
    chk_rd("pb_dir", 8'h00, 5'h11);
    chk_rd("pb_lcd", 8'h00, 5'h01);
    chk_rd("pull", 8'h00, 5'h19);
    chk_rd("odrain", 8'h00, 5'h1a);
    chk_rd("unmapped", 8'h00, 5'h07);
    wr(5'h01, 8'h5a);
    lcd_fp <= 8'hc3;
    settle();
    chk_pin("pb_lcd_wr", 8'hc3, pb_o);
    do_reset();
    wr(5'h1b, 8'h01);
    wr(5'h11, 8'h0f);
    settle();
    chk_pin("pb_mix", 8'hca, pb_o);
    chk_rd("pb_mix", 8'h0a, 5'h01);
    // Port mode on both nibbles before any pull-up is set
    wr(5'h1b, 8'h03);
    wr(5'h11, 8'hf0);
    pb_xen <= 8'h0f;
    pb_xv <= 8'h06;
    settle();
    chk_rd("pb_in", 8'h56, 5'h01);
    chk_pin("pb_dir", 8'hf0, pb_oe_o);
    wr(5'h1a, 8'h02);
    wr(5'h19, 8'h02);
    settle();
    chk_pin("pb_od", 8'ha0, pb_oe_o);
    chk_pin("pb_pull", 8'hf0, pb_pull_o);
    $display("test port_b done");
  endtask : t_port_b
  task automatic t_port_a();
    wr(5'h19, 8'h04);
    wr(5'h10, 8'h00);
    wr(5'h00, 8'h00);
    settle();
    chk_pin("pa_in", 8'h01, {7'h0, pa7_pull_o});
    chk_pin("pa_in_oe", 8'h00, {7'h0, pa7_oe_o});
    chk_rd("pa_pin", 8'h80, 5'h00);
    wr(5'h10, 8'h80);
    settle();
    chk_pin("pa_drv", 8'h02, {6'h0, pa7_oe_o, pa7_o});
    wr(5'h1a, 8'h04);
    wr(5'h00, 8'h80);
    settle();
    chk_pin("pa_od", 8'h00, {7'h0, pa7_oe_o});
    $display("test port_a done");
  endtask : t_port_a
  task automatic t_port_c();
    wr(5'h19, 8'h08);
    wr(5'h1a, 8'h00);
    wr(5'h02, 8'h0e);
    wr(5'h12, 8'h0f);
    settle();
    chk_pin("pc_oe", 8'h03, {4'h0, pc_oe_o});
    chk_pin("pc_out", 8'h02, {5'h0, pc_o[2:0]});
    chk_pin("pc_pull", 8'h0c, {4'h0, pc_pull_o});
    chk_rd("pc_pins", 8'h0e, 5'h02);
    chk_rd("pc_regs", 8'h08, 5'h19);
    chk_pin("pc_irq", 8'h01, {7'h0, irq});
    chk_pin("pc_sck_in", 8'h00, {7'h0, sck_in});
    pc_xen <= 4'h8;
    pc_xv <= 4'h0;
    settle();
    chk_rd("pc3_low", 8'h06, 5'h02);
    // Clock pin released high before the serial function is switched on
    wr(5'h12, 8'h00);
    pc_xen <= 4'hd;
    pc_xv <= 4'h5;
    settle();
    wr(5'h1c, 8'h03);
    settle();
    chk_pin("spi_ctl", 8'h03, {6'h0, serial_master_select, serial_enable_bit});
    chk_pin("spi_drv", 8'h03, {6'h0, pc_oe_o[1:0]});
    chk_pin("spi_out", 8'h01, {6'h0, pc_o[1:0]});
    chk_pin("spi_in", 8'h01, {7'h0, sdi});
    chk_rd("pc_spi", 8'h05, 5'h02);
    sdo <= 1'b1;
    wr(5'h1c, 8'h01);
    settle();
    chk_pin("spi_slave_oe", 8'h02, {6'h0, pc_oe_o[1:0]});
    chk_pin("spi_slave_sdo", 8'h01, {7'h0, pc_o[1]});
    chk_pin("spi_slave_sck", 8'h01, {7'h0, sck_in});
    $display("test port_c done");
  endtask : t_port_c
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    do_reset();
    t_port_b();
    t_port_a();
    t_port_c();
    final_report();
  end
endmodule : spio_top_tb
